// >>> bench/cil_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cil_checker
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst,
   input wire logic        i_chain_enable_in,
   input wire logic [2:0]  i_onchip_vec_req,
   input wire logic        i_instr_fetch,
   input wire logic [23:0] o_addr,
   input wire logic        o_io_request_strobe_n,
   input wire logic        o_opcode_fetch_strobe_n,
   input wire logic        o_io_read_strobe_n,
   input wire logic        o_io_write_strobe_n,
   input wire logic        o_push,
   input wire logic        o_fetch,
   input wire logic [31:0] o_fetch_addr,
   input wire logic        o_svc_valid,
   input wire logic [3:0]  o_svc_src,
   input wire logic [31:0] o_svc_target,
   input wire logic        o_irq_enable_ff_a,
   input wire logic        o_irq_enable_ff_b,
   input wire logic        o_chain_enable_out
);
   wire ack_on = !o_io_request_strobe_n;
   wire chain_exp = i_chain_enable_in && !(|i_onchip_vec_req);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // push, table fetch, service in turn
   sequence s_tail;
      o_push ##1 o_fetch ##1 o_svc_valid;
   endsequence
   a_ack_high: assert property (ack_on |->
      o_addr[23:4] == 20'hFFFFF && $countones(~o_addr[3:0]) <= 1) else $error("ack address");
   a_ack_quiet: assert property (ack_on |->
      o_io_read_strobe_n && o_io_write_strobe_n) else $error("io strobes in ack");
   a_ack_three: assert property ($fell(o_io_request_strobe_n) |->
      !o_io_request_strobe_n[*3] ##1 o_io_request_strobe_n) else $error("ack length");
   a_assigned_seq: assert property ($fell(o_io_request_strobe_n) &&
      o_opcode_fetch_strobe_n |-> ##3 s_tail) else $error("assigned order");
   a_clear_both: assert property (o_svc_valid && o_svc_src >= 4'h2 |->
      !o_irq_enable_ff_a && !o_irq_enable_ff_b) else $error("enables not cleared");
   a_nmi_target: assert property (o_svc_valid && o_svc_src == 4'h1 |->
      o_svc_target == 32'h0000_0066) else $error("nmi target");
   a_trap_target: assert property (o_svc_valid && o_svc_src == 4'h0 |->
      o_svc_target == 32'h0 && $past(o_push)) else $error("trap target");
   a_fetch_even: assert property (o_fetch |->
      !o_fetch_addr[0] && o_addr == o_fetch_addr[23:0]) else $error("fetch address");
   a_fetch_strobe: assert property (i_instr_fetch |=>
      !o_opcode_fetch_strobe_n) else $error("opcode strobe");
   a_chain_out: assert property (!$past(i_rst) |->
      o_chain_enable_out == $past(chain_exp)) else $error("chain out");
endmodule // cil_checker
bind cil_top cil_checker u_chk (.*);
`default_nettype wire

// >>> bench/cil_peer.sv
`timescale 1ns/1ps
`default_nettype none
module cil_peer
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_io_request_strobe_n,
   input  wire logic        i_opcode_fetch_strobe_n,
   input  wire logic [15:0] i_vec,
   input  wire logic        i_narrow,
   input  wire logic        i_bad,
   output logic [15:0]      o_data,
   output logic             o_vec_undef
);
   logic [15:0] last_ff = 16'h0000;
   wire ack = !i_io_request_strobe_n && !i_opcode_fetch_strobe_n;
   wire [7:0] pull = i_narrow ? 8'hFF : 8'h00;
   always_ff @(posedge i_clk_sys)
   begin
      if (ack) last_ff <= o_data;
   end
   // vector only in acknowledge, else lines wander
   assign o_data = ack ? {pull | i_vec[15:8], i_vec[7:0]} : ~last_ff | {pull, 8'h00};
   assign o_vec_undef = ack && i_bad;
endmodule // cil_peer
`default_nettype wire

// >>> bench/cil_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cil_top_tb_top;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic [31:0] i_avs_writedata = 32'h0, i_sp = 32'h0;
   logic [3:0] i_avs_byteenable = 4'hF, i_ei_sel = 4'h0;
   logic i_nmi_n = 1'b1, i_vectored_request_0_n = 1'b1, i_assigned_request_1_n = 1'b1;
   logic i_assigned_request_2_n = 1'b1, i_assigned_request_3_n = 1'b1;
   logic [2:0] i_onchip_vec_req = 3'h0;
   logic [7:0] i_periph_req = 8'h00, i_ireg = 8'h00;
   logic i_chain_enable_in = 1'b1, i_boundary = 1'b0, i_instr_fetch = 1'b0;
   logic i_undef_fetch = 1'b0, i_ei = 1'b0, i_di = 1'b0;
   wire logic [15:0] i_data;
   wire logic i_vec_undef;
   logic [31:0] o_avs_readdata, o_push_sp, o_fetch_addr, o_svc_target;
   logic o_avs_waitrequest, o_chain_enable_out, o_push, o_push_32, o_fetch, o_fetch_32;
   logic o_io_request_strobe_n, o_opcode_fetch_strobe_n, o_io_read_strobe_n;
   logic o_io_write_strobe_n, o_svc_valid, o_irq_enable_ff_a, o_irq_enable_ff_b;
   logic [2:0] o_onchip_ack, oack;
   logic [23:0] o_addr, ack_a;
   logic [3:0] o_svc_src, src;
   logic [31:0] tgt, psp, fa, rd;
   logic [15:0] vec = 16'h0;
   logic seen, p32, f32, narrow = 1'b0, bad = 1'b0;
   int n_mismatch = 0, samples_checked = 0;
   cil_top i_dut (.*);
   cil_peer i_peer (.i_clk_sys, .i_io_request_strobe_n(o_io_request_strobe_n),
      .i_opcode_fetch_strobe_n(o_opcode_fetch_strobe_n), .i_vec(vec), .i_narrow(narrow),
      .i_bad(bad), .o_data(i_data), .o_vec_undef(i_vec_undef));
   always #20 i_clk_sys = ~i_clk_sys;
   ////////////////////////////////////////
   task chk(input logic [31:0] v, input logic [31:0] e);
      samples_checked++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
      end
   endtask
   task tick(input int c);
      repeat (c) @(posedge i_clk_sys);
   endtask
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do
         @(posedge i_clk_sys);
      while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task arm(input logic [31:0] c);
      bus(1'b1, 5'h14, c | 32'h18);
   endtask
   // one boundary, then collect the whole sequence
   task serve(input logic want, input logic [3:0] es);
      int n;
      seen = 1'b0;
      oack = 3'h0;
      @(posedge i_clk_sys);
      i_boundary <= 1'b1;
      @(posedge i_clk_sys);
      i_boundary <= 1'b0;
      for (n = 0; n < 12 && !seen; n++)
      begin
         @(posedge i_clk_sys);
         if (o_push === 1'b1) {p32, psp} = {o_push_32, o_push_sp};
         if (o_fetch === 1'b1) {f32, fa} = {o_fetch_32, o_fetch_addr};
         if (o_io_request_strobe_n === 1'b0) {ack_a, oack} = {o_addr, o_onchip_ack};
         if (o_svc_valid === 1'b1) {seen, src, tgt} = {1'b1, o_svc_src, o_svc_target};
      end
      chk(seen, want);
      if (want) chk(src, es);
   endtask
   ////////////////////////////////////////
   task t_regs;
      bus(1'b0, 5'h00, 32'h0);
      chk(rd[3:0], 4'h0);
      bus(1'b1, 5'h00, 32'hF);
      i_assigned_request_1_n <= 1'b0;
      tick(3);
      bus(1'b0, 5'h00, 32'h0);
      chk({rd[5], rd[3:0]}, 5'h1F);
      i_assigned_request_1_n <= 1'b1;
      bus(1'b1, 5'h04, 32'hFF);
      bus(1'b0, 5'h04, 32'h0);
      chk(rd, 32'hFE);
      bus(1'b0, 5'h18, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 5'h04, 32'hA4);
      bus(1'b1, 5'h10, 32'h1234);
      i_instr_fetch <= 1'b1;
      tick(2);
      chk(o_opcode_fetch_strobe_n, 1'b0);
      i_instr_fetch <= 1'b0;
   endtask
   task t_trap;
      arm(32'h4);
      i_sp <= 32'h0001_0000;
      i_undef_fetch <= 1'b1;
      i_nmi_n <= 1'b0;
      tick(1);
      i_undef_fetch <= 1'b0;
      tick(4);
      serve(1'b1, 4'h0);
      chk(psp, 32'h0000_FFFC);
      chk(p32, 1'b1);
      serve(1'b1, 4'h1);
      bus(1'b0, 5'h0C, 32'h0);
      chk(rd, 32'h1);
      bus(1'b1, 5'h0C, 32'h3);
      bus(1'b0, 5'h0C, 32'h0);
      chk(rd, 32'h0);
      i_nmi_n <= 1'b1;
   endtask
   task t_assigned;
      int k;
      logic [8:0] v;
      for (k = 0; k < 10; k++)
      begin
         v = (k == 0) ? 9'h004 : 9'(4 * (k + 2));
         i_assigned_request_2_n <= (k != 0);
         i_assigned_request_3_n <= (k != 9);
         i_periph_req <= (k == 0 || k == 9) ? 8'h00 : 8'h01 << (k - 1);
         arm((k == 9) ? 32'h4 : 32'h0);
         tick(4);
         serve(1'b1, 4'(k + 4));
         chk(tgt, {16'h1234, 7'h52, v});
         chk(fa, {16'h1234, 7'h52, v});
         chk(f32, k == 9);
         chk(ack_a[3:0], (k == 0) ? 4'hB : ((k == 9) ? 4'h7 : 4'hF));
         chk({o_irq_enable_ff_a, o_irq_enable_ff_b}, 2'b00);
      end
      i_assigned_request_3_n <= 1'b1;
      i_periph_req <= 8'h00;
   endtask
   task t_priority;
      arm(32'h0);
      i_nmi_n <= 1'b0;
      i_assigned_request_1_n <= 1'b0;
      i_assigned_request_2_n <= 1'b0;
      tick(5);
      serve(1'b1, 4'h1);
      chk(tgt, 32'h0000_0066);
      chk(psp, 32'h0001_FFFE);
      chk(p32, 1'b0);
      arm(32'h0);
      serve(1'b1, 4'h3);
      i_assigned_request_1_n <= 1'b1;
      tick(4);
      arm(32'h0);
      serve(1'b1, 4'h4);
      i_assigned_request_2_n <= 1'b1;
      i_nmi_n <= 1'b1;
   endtask
   task t_edge;
      bus(1'b1, 5'h08, 32'h2);
      i_assigned_request_1_n <= 1'b0;
      tick(3);
      i_assigned_request_1_n <= 1'b1;
      tick(4);
      arm(32'h0);
      serve(1'b1, 4'h3);
      arm(32'h0);
      serve(1'b1, 4'h3);
      bus(1'b1, 5'h08, 32'h102);
      arm(32'h0);
      serve(1'b0, 4'h0);
      bus(1'b1, 5'h08, 32'h1);
      arm(32'h0);
      serve(1'b1, 4'h3);
      bus(1'b1, 5'h08, 32'h0);
   endtask
   task t_vectored;
      i_ireg <= 8'h9C;
      vec <= 16'h0057;
      i_onchip_vec_req <= 3'b011;
      arm(32'h22);
      serve(1'b1, 4'h2);
      chk(fa[15:0], 16'h9C56);
      chk(oack, 3'b010);
      i_onchip_vec_req <= 3'b000;
      narrow <= 1'b1;
      vec <= 16'h0042;
      i_vectored_request_0_n <= 1'b0;
      arm(32'h3);
      tick(4);
      serve(1'b1, 4'h2);
      chk(fa[15:0], 16'hFF42);
      arm(32'h1);
      serve(1'b1, 4'h2);
      chk(tgt, 32'h0000_0038);
      bad <= 1'b1;
      arm(32'h0);
      serve(1'b0, 4'h0);
      i_vectored_request_0_n <= 1'b1;
      bad <= 1'b0;
      serve(1'b1, 4'h0);
      bus(1'b0, 5'h0C, 32'h0);
      chk(rd, 32'h2);
   endtask
   ////////////////////////////////////////
   task wrap_up;
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial
   begin
      tick(8);
      i_rst <= 1'b0;
      t_regs();
      t_trap();
      t_assigned();
      t_priority();
      t_edge();
      t_vectored();
      tick(4);
      wrap_up();
   end
   initial
   begin
      #400000;
      n_mismatch++;
      wrap_up();
   end
endmodule // cil_top_tb_top
`default_nettype wire

// >>> include/cil_cfg.svh
`ifndef CIL_CFG_SVH
`define CIL_CFG_SVH
`define CIL_A_IER    3'h0
`define CIL_A_BASE   3'h1
`define CIL_A_SENSE  3'h2
`define CIL_A_TRAP   3'h3
`define CIL_A_EXT    3'h4
`define CIL_A_CTRL   3'h5
`define CIL_ACK_CYC  3'h2
`define CIL_NMI_ADDR 32'h0000_0066
`define CIL_M1_ADDR  32'h0000_0038
`define CIL_TRAP_ADDR 32'h0000_0000
`define CIL_SRC_TRAP 4'h0
`define CIL_SRC_NMI  4'h1
`define CIL_SRC_VECTORED_REQUEST_0_N 4'h2
`define CIL_SRC_ASSIGNED_REQUEST_1_N 4'h3
`define CIL_SRC_ASSIGNED_REQUEST_2_N 4'h4
`define CIL_SRC_ASSIGNED_REQUEST_3_N 4'hD
`define CIL_SLOT_I3  4'hB
`define CIL_NSRC     14
`define CIL_HI_ADDR  20'hFFFFF
`define CIL_W_VECTORED_REQUEST_0_N   4'hE
`define CIL_CLR_LSB  8
`endif

// >>> include/cil_pkg.sv
package cil_pkg;
   typedef enum logic [2:0] {
      CIL_IDLE  = 3'b000,
      CIL_ACK   = 3'b001,
      CIL_PUSH  = 3'b010,
      CIL_FETCH = 3'b011,
      CIL_DONE  = 3'b100
   } cil_state_t;
   typedef enum logic [1:0] {
      CIL_MODE0 = 2'b00,
      CIL_MODE1 = 2'b01,
      CIL_MODE2 = 2'b10,
      CIL_MODE3 = 2'b11
   } cil_mode_t;
endpackage

// >>> logic/cil_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cil_cfg.svh"
module cil_top
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic [4:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_nmi_n,
   input  wire logic        i_vectored_request_0_n,
   input  wire logic        i_assigned_request_1_n,
   input  wire logic        i_assigned_request_2_n,
   input  wire logic        i_assigned_request_3_n,
   input  wire logic [2:0]  i_onchip_vec_req,
   input  wire logic [7:0]  i_periph_req,
   input  wire logic        i_chain_enable_in,
   output logic             o_chain_enable_out,
   output logic [2:0]       o_onchip_ack,
   input  wire logic        i_boundary,
   input  wire logic        i_instr_fetch,
   input  wire logic        i_undef_fetch,
   input  wire logic        i_ei,
   input  wire logic        i_di,
   input  wire logic [3:0]  i_ei_sel,
   input  wire logic [15:0] i_data,
   input  wire logic        i_vec_undef,
   input  wire logic [7:0]  i_ireg,
   input  wire logic [31:0] i_sp,
   output logic [23:0]      o_addr,
   output logic             o_io_request_strobe_n,
   output logic             o_opcode_fetch_strobe_n,
   output logic             o_io_read_strobe_n,
   output logic             o_io_write_strobe_n,
   output logic             o_push,
   output logic             o_push_32,
   output logic [31:0]      o_push_sp,
   output logic             o_fetch,
   output logic             o_fetch_32,
   output logic [31:0]      o_fetch_addr,
   output logic             o_svc_valid,
   output logic [3:0]       o_svc_src,
   output logic [31:0]      o_svc_target,
   output logic             o_irq_enable_ff_a,
   output logic             o_irq_enable_ff_b
);
   import cil_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [4:0]  s1_ff;
   logic [4:0]  s2_ff;
   logic [4:0]  prev_ff;
   wire  [4:0]  pins = {i_assigned_request_3_n, i_assigned_request_2_n,
                        i_assigned_request_1_n, i_vectored_request_0_n, i_nmi_n};

   always_ff @(posedge i_clk_sys)
   begin
      s1_ff   <= pins;
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff;
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic [3:0]  ier_ff;
   logic [6:0]  base_ff;
   logic [5:0]  sense_ff;
   logic [1:0]  trap_ff;
   logic [15:0] ext_ff;
   cil_mode_t   mode_ff;
   logic        xmode_ff;
   logic [1:0]  order_ff;
   logic        iefa_ff;
   logic        iefb_ff;

   wire [2:0]  ra     = i_avs_address[4:2];
   wire        req    = i_avs_read | i_avs_write;
   wire        wr_hit = i_avs_write & ~wait_ff;
   wire [31:0] wd     = i_avs_writedata;
   wire        we_ier = wr_hit & (ra == `CIL_A_IER);
   wire        we_bas = wr_hit & (ra == `CIL_A_BASE);
   wire        we_sen = wr_hit & (ra == `CIL_A_SENSE);
   wire        we_trp = wr_hit & (ra == `CIL_A_TRAP);
   wire        we_ext = wr_hit & (ra == `CIL_A_EXT);
   wire        we_ctl = wr_hit & (ra == `CIL_A_CTRL);
   wire [3:0]  pin_stat = ~s2_ff[4:1];

   wire [31:0] rmux =
      (ra == `CIL_A_IER)   ? {24'h0, pin_stat, ier_ff} :
      (ra == `CIL_A_BASE)  ? {24'h0, base_ff, 1'b0} :
      (ra == `CIL_A_SENSE) ? {26'h0, sense_ff} :
      (ra == `CIL_A_TRAP)  ? {30'h0, trap_ff} :
      (ra == `CIL_A_EXT)   ? {16'h0, ext_ff} :
      (ra == `CIL_A_CTRL)  ? {25'h0, order_ff, iefb_ff, iefa_ff,
                              xmode_ff, mode_ff} :
      32'h0;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0;
      end
      else
      begin
         wait_ff  <= ~(req & wait_ff);
         rdata_ff <= (i_avs_read & wait_ff) ? rmux : rdata_ff;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         base_ff  <= 7'h0;
         sense_ff <= 6'h0;
         ext_ff   <= 16'h0;
         mode_ff  <= CIL_MODE0;
         xmode_ff <= 1'b0;
         order_ff <= 2'h0;
      end
      else
      begin
         if (we_bas) base_ff <= wd[7:1];
         if (we_sen) sense_ff <= wd[5:0];
         if (we_ext) ext_ff <= wd[15:0];
         if (we_ctl) mode_ff <= cil_mode_t'(wd[1:0]);
         if (we_ctl) xmode_ff <= wd[2];
         if (we_ctl) order_ff <= wd[6:5];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // request conditioning
   logic [2:0] edge_ff;
   logic [2:0] pend13;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_req
         wire [1:0] sn  = sense_ff[2*gi+1:2*gi];
         wire       pin = s2_ff[gi+2];
         wire       old = prev_ff[gi+2];
         wire       hit = (sn == 2'h2 & old & ~pin) | (sn == 2'h3 & ~old & pin);
         wire       clr = we_sen & wd[`CIL_CLR_LSB+gi];
         always_ff @(posedge i_clk_sys)
         begin
            if (i_rst)
               edge_ff[gi] <= 1'b0;
            else
               edge_ff[gi] <= hit | (edge_ff[gi] & ~clr);
         end
         assign pend13[gi] = sn[1] ? edge_ff[gi] : (pin == sn[0]);
      end
   endgenerate

   logic       nmi_ff;
   logic       trapp_ff;
   cil_state_t st_ff;
   logic [3:0] src_ff;
   logic [2:0] cnt_ff;
   logic [15:0] vec_ff;

   wire vectored_request_0_n = ~s2_ff[1] | (|i_onchip_vec_req);
   wire [`CIL_NSRC-1:0] reqs = {
      pend13[2] & ier_ff[3] & iefa_ff,
      i_periph_req & {8{iefa_ff}},
      pend13[1] & ier_ff[2] & iefa_ff,
      pend13[0] & ier_ff[1] & iefa_ff,
      vectored_request_0_n & ier_ff[0] & iefa_ff,
      nmi_ff,
      trapp_ff};

   logic [3:0] win;
   always_comb
   begin
      win = 4'h0;
      for (int i = `CIL_NSRC - 1; i >= 0; i--)
         if (reqs[i]) win = 4'(i);
   end

   wire start   = (st_ff == CIL_IDLE) & i_boundary & (|reqs);
   wire is_i0   = src_ff == `CIL_SRC_VECTORED_REQUEST_0_N;
   wire ack_end = (st_ff == CIL_ACK) & (cnt_ff == `CIL_ACK_CYC);
   wire m0_bad  = ack_end & is_i0 & (mode_ff == CIL_MODE0) & i_vec_undef;
   wire nmi_fall = prev_ff[0] & ~s2_ff[0];
   wire served_n = start & (win == `CIL_SRC_NMI);
   wire served_t = start & (win == `CIL_SRC_TRAP);
   wire masked   = start & (win > `CIL_SRC_NMI);

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         nmi_ff   <= 1'b0;
         trapp_ff <= 1'b0;
         trap_ff  <= 2'h0;
      end
      else
      begin
         nmi_ff   <= nmi_fall | (nmi_ff & ~served_n);
         trapp_ff <= i_undef_fetch | m0_bad | (trapp_ff & ~served_t);
         trap_ff[0] <= i_undef_fetch | (trap_ff[0] & ~(we_trp & wd[0]));
         trap_ff[1] <= m0_bad | (trap_ff[1] & ~(we_trp & wd[1]));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // enables
   wire [3:0] nxt_ier = we_ier ? wd[3:0] :
                        i_ei ? (ier_ff | i_ei_sel) :
                        i_di ? (ier_ff & ~i_ei_sel) : ier_ff;
   wire nxt_iefa = masked | served_n ? 1'b0 :
                   we_ctl ? wd[3] : i_ei ? 1'b1 : i_di ? 1'b0 : iefa_ff;
   wire nxt_iefb = masked ? 1'b0 :
                   we_ctl ? wd[4] : i_ei ? 1'b1 : i_di ? 1'b0 : iefb_ff;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         ier_ff  <= 4'h0;
         iefa_ff <= 1'b0;
         iefb_ff <= 1'b0;
      end
      else
      begin
         ier_ff  <= nxt_ier;
         iefa_ff <= nxt_iefa;
         iefb_ff <= nxt_iefb;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // acknowledge sequencer
   wire no_ack  = (win == `CIL_SRC_TRAP) | (win == `CIL_SRC_NMI);
   wire mode0   = is_i0 & (mode_ff == CIL_MODE0);
   wire mode1   = is_i0 & (mode_ff == CIL_MODE1);
   wire tabled  = ~is_i0 | (mode_ff == CIL_MODE2) | (mode_ff == CIL_MODE3);
   wire sys_src = (src_ff == `CIL_SRC_TRAP) | (src_ff == `CIL_SRC_NMI);

   cil_state_t nxt_st;
   always_comb
   begin
      case (st_ff)
         CIL_IDLE:  nxt_st = start ? (no_ack ? CIL_PUSH : CIL_ACK) : CIL_IDLE;
         CIL_ACK:   nxt_st = ~ack_end ? CIL_ACK : m0_bad ? CIL_IDLE :
                             mode0 ? CIL_DONE : CIL_PUSH;
         CIL_PUSH:  nxt_st = (~sys_src & tabled) ? CIL_FETCH : CIL_DONE;
         CIL_FETCH: nxt_st = CIL_DONE;
         CIL_DONE:  nxt_st = CIL_IDLE;
         default:   nxt_st = CIL_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         st_ff  <= CIL_IDLE;
         src_ff <= 4'h0;
         cnt_ff <= 3'h0;
         vec_ff <= 16'h0;
      end
      else
      begin
         st_ff  <= nxt_st;
         src_ff <= start ? win : src_ff;
         cnt_ff <= (st_ff == CIL_ACK) ? cnt_ff + 3'h1 : 3'h0;
         vec_ff <= ack_end ? i_data : vec_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // addresses and vectors
   wire [3:0] slot = (src_ff == `CIL_SRC_ASSIGNED_REQUEST_1_N) ? 4'h0 :
                     (src_ff == `CIL_SRC_ASSIGNED_REQUEST_2_N) ? 4'h1 :
                     (src_ff == `CIL_SRC_ASSIGNED_REQUEST_3_N) ? `CIL_SLOT_I3 :
                     src_ff - 4'h2;
   wire [8:0] avec = {3'h0, slot, 2'h0};
   wire [15:0] ivec = (mode_ff == CIL_MODE3) ? vec_ff :
                      {i_ireg, vec_ff[7:0]};
   wire [31:0] taddr = is_i0 ? {ext_ff, ivec[15:1], 1'b0} :
                       {ext_ff, base_ff, avec};
   wire [3:0] line = (src_ff == `CIL_SRC_VECTORED_REQUEST_0_N) ? 4'hE :
                     (src_ff == `CIL_SRC_ASSIGNED_REQUEST_1_N) ? 4'hD :
                     (src_ff == `CIL_SRC_ASSIGNED_REQUEST_2_N) ? 4'hB :
                     (src_ff == `CIL_SRC_ASSIGNED_REQUEST_3_N) ? 4'h7 : 4'hF;
   wire [31:0] spn = xmode_ff ? i_sp - 32'h4 :
                     {i_sp[31:16], i_sp[15:0] - 16'h2};
   wire [31:0] tgt = (src_ff == `CIL_SRC_NMI) ? `CIL_NMI_ADDR :
                     (src_ff == `CIL_SRC_TRAP) ? `CIL_TRAP_ADDR :
                     mode1 ? `CIL_M1_ADDR :
                     mode0 ? {16'h0, vec_ff} : taddr;

   ////////////////////////////////////////////////////////////////////
   // on-chip daisy chain
   wire [2:0] rot = (order_ff == 2'h1) ? {i_onchip_vec_req[0], i_onchip_vec_req[2:1]} :
                    (order_ff == 2'h2) ? {i_onchip_vec_req[1:0], i_onchip_vec_req[2]} :
                    i_onchip_vec_req;
   wire [2:0] rg  = rot[0] ? 3'h1 : rot[1] ? 3'h2 : rot[2] ? 3'h4 : 3'h0;
   wire [2:0] gnt = (order_ff == 2'h1) ? {rg[1:0], rg[2]} :
                    (order_ff == 2'h2) ? {rg[0], rg[2:1]} : rg;

   ////////////////////////////////////////////////////////////////////
   // output registers
   wire in_ack = nxt_st == CIL_ACK;
   wire in_fet = nxt_st == CIL_FETCH;
   wire nis_i0 = start ? (win == `CIL_SRC_VECTORED_REQUEST_0_N) : is_i0;
   wire as_ack = in_ack & ~nis_i0;
   wire [3:0] nsrc = start ? win : src_ff;
   wire [3:0] nline = start ? ((win == `CIL_SRC_VECTORED_REQUEST_0_N) ? 4'hE :
                               (win == `CIL_SRC_ASSIGNED_REQUEST_1_N) ? 4'hD :
                               (win == `CIL_SRC_ASSIGNED_REQUEST_2_N) ? 4'hB :
                               (win == `CIL_SRC_ASSIGNED_REQUEST_3_N) ? 4'h7 : 4'hF) : line;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_addr                  <= 24'h0;
         o_io_request_strobe_n   <= 1'b1;
         o_opcode_fetch_strobe_n <= 1'b1;
         o_io_read_strobe_n      <= 1'b1;
         o_io_write_strobe_n     <= 1'b1;
         o_push                  <= 1'b0;
         o_push_32               <= 1'b0;
         o_push_sp               <= 32'h0;
         o_fetch                 <= 1'b0;
         o_fetch_32              <= 1'b0;
         o_fetch_addr            <= 32'h0;
         o_svc_valid             <= 1'b0;
         o_svc_src               <= 4'h0;
         o_svc_target            <= 32'h0;
         o_chain_enable_out      <= 1'b0;
         o_onchip_ack            <= 3'h0;
      end
      else
      begin
         o_addr <= in_ack ? {`CIL_HI_ADDR, nline} :
                   in_fet ? taddr[23:0] : o_addr;
         o_io_request_strobe_n   <= ~in_ack;
         o_opcode_fetch_strobe_n <= ~(i_instr_fetch | (in_ack & ~as_ack));
         o_io_read_strobe_n      <= 1'b1;
         o_io_write_strobe_n     <= 1'b1;
         o_push      <= nxt_st == CIL_PUSH;
         o_push_32   <= xmode_ff;
         o_push_sp   <= spn;
         o_fetch     <= in_fet;
         o_fetch_32  <= xmode_ff;
         o_fetch_addr <= in_fet ? taddr : o_fetch_addr;
         o_svc_valid <= nxt_st == CIL_DONE;
         o_svc_src   <= nsrc;
         o_svc_target <= tgt;
         o_chain_enable_out <= i_chain_enable_in & ~(|i_onchip_vec_req);
         o_onchip_ack <= (in_ack & nis_i0 & i_chain_enable_in) ? gnt : 3'h0;
      end
   end

   assign o_avs_readdata    = rdata_ff;
   assign o_avs_waitrequest = wait_ff;
   assign o_irq_enable_ff_a = iefa_ff;
   assign o_irq_enable_ff_b = iefb_ff;

endmodule // cil_top
`default_nettype wire
